// ==== dv/lip_bus_sva.sv ====
// Checker for the pins between the host end and the device end of the parallel port.
// Assumes it watches the first interface of the bench, where both parties are design modules.
`include "lip_map.svh"

module lip_bus_sva (
	input  wire logic       CLOCK_IN,             // System clock.
	input  wire logic       SRST_IN,              // Reset, active high.
	input  wire logic       chip_select_n,        // Chip select.
	input  wire logic       read_strobe_n,        // Read strobe.
	input  wire logic       write_strobe_n,       // Write strobe.
	input  wire logic       addr_latch_strobe,    // Latch strobe.
	input  wire logic [4:0] separate_addr_inputs, // Address pins.
	input  wire logic [1:0] bus_select_straps,    // Straps.
	input  wire logic       bus_timing_strap,     // Timing strap.
	input  wire logic       host_data_oe,         // Host drive.
	input  wire logic       dev_data_oe,          // Device drive.
	input  wire logic       dev_irq,              // Interrupt level.
	input  wire logic       dev_irq_oe,           // Interrupt pull.
	input  wire logic       irq_n                 // Resolved interrupt line.
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);

	mux_addr_low_a: assert property (bus_select_straps == `LIP_SEL_MUX |-> separate_addr_inputs == 5'h00)
		else $error("address pins not low in muxed mode");
	nonmux_ale_low_a: assert property (bus_select_straps == `LIP_SEL_NONMUX |-> !addr_latch_strobe)
		else $error("latch strobe high in nonmuxed mode");
	strobe_cs_a: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
		else $error("strobe active without chip select");
	cs_frame_a: assert property ($fell(chip_select_n) |-> ##40 $rose(chip_select_n))
		else $error("chip select frame length wrong");
	latch_pulse_a: assert property ($rose(addr_latch_strobe) |->
		(addr_latch_strobe && host_data_oe)[*8] ##1 !addr_latch_strobe)
		else $error("address not held across latch strobe");
	read_drive_a: assert property ($fell(read_strobe_n) && !chip_select_n && write_strobe_n |-> ##3 dev_data_oe)
		else $error("device did not drive read data");
	read_release_a: assert property ($rose(read_strobe_n) |-> ##3 !dev_data_oe)
		else $error("device kept driving after read");
	idle_release_a: assert property (chip_select_n && $past(chip_select_n, 3) |-> !dev_data_oe)
		else $error("device drives while deselected");
	write_data_a: assert property (!write_strobe_n && !bus_timing_strap |-> host_data_oe && !dev_data_oe)
		else $error("data lines not host driven during write");
	irq_drain_a: assert property (dev_irq_oe |-> dev_irq == 1'b0 && !irq_n)
		else $error("interrupt pin not pulled low");
	irq_release_a: assert property (!dev_irq_oe |-> irq_n)
		else $error("interrupt line low while released");

	cover property ($rose(read_strobe_n) && bus_select_straps == `LIP_SEL_MUX);
	cover property ($rose(write_strobe_n) && bus_select_straps == `LIP_SEL_NONMUX);
	cover property ($rose(dev_irq_oe));
endmodule : lip_bus_sva

// ==== dv/tb_line_interface_parallel_host_port.sv ====
// Bench that joins the host end to the device end and drives both user sides.
// Assumes the design files and lip_map.svh are compiled first; a second device faces the bench directly.
module tb_line_interface_parallel_host_port;
	timeunit 1ns;
	timeprecision 1ns;

	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         cmd_valid = 1'b0;
	logic         cmd_write = 1'b0;
	logic [4:0]   cmd_addr = 5'h00;
	logic [7:0]   cmd_data = 8'h00;
	logic [1:0]   bus_sel = 2'h0;
	logic         bus_timing = 1'b0;
	logic         hard_reset = 1'b0;
	logic         mclk = 1'b0;
	logic         mclk_run = 1'b1;
	logic [6:0]   line_cond = 7'h00;
	logic         cmd_ready;
	logic         resp_valid;
	logic         irq;
	logic [7:0]   resp_data;
	logic [231:0] ctrl;
	logic [231:0] ctrl2;
	int           n_mismatch = 0;
	int           checks_done = 0;

	lip_bus_if bus ();
	lip_bus_if bus2 ();

	always #20 clk = ~clk;
	// Roughly 2.048 MHz; stopping it lets the device see a lost master clock.
	always #244 mclk = mclk_run ? ~mclk : mclk;

	lip_host lip_host_inst (.bus(bus), .CLOCK_IN(clk), .SRST_IN(srst), .CMD_VALID_IN(cmd_valid),
		.CMD_WRITE_IN(cmd_write), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data), .BUS_SELECT_IN(bus_sel),
		.BUS_TIMING_IN(bus_timing), .HARD_RESET_IN(hard_reset), .CMD_READY_OUT(cmd_ready),
		.RESP_VALID_OUT(resp_valid), .RESP_DATA_OUT(resp_data), .IRQ_OUT(irq));
	lip_device lip_device_inst (.bus(bus), .CLOCK_IN(clk), .SRST_IN(srst), .MASTER_CLOCK_IN(mclk),
		.LINE_COND_IN(line_cond), .LINE_CTRL_OUT(ctrl));
	lip_device lip_device_inst_2 (.bus(bus2), .CLOCK_IN(clk), .SRST_IN(srst), .MASTER_CLOCK_IN(mclk),
		.LINE_COND_IN(line_cond), .LINE_CTRL_OUT(ctrl2));
	lip_bus_sva lip_bus_sva_inst (.CLOCK_IN(clk), .SRST_IN(srst), .chip_select_n(bus.chip_select_n),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.addr_latch_strobe(bus.addr_latch_strobe), .separate_addr_inputs(bus.separate_addr_inputs),
		.bus_select_straps(bus.bus_select_straps), .bus_timing_strap(bus.bus_timing_strap),
		.host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe), .dev_irq(bus.dev_irq),
		.dev_irq_oe(bus.dev_irq_oe), .irq_n(bus.irq_n));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic do_cmd(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr <= a;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (resp_valid !== 1'b1 && n < 100);
		check("latency", 8'(n), 8'h28);
		q = resp_data;
	endtask : do_cmd

	task automatic test_modes();
		logic [7:0] q;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			bus_sel <= {1'b0, m[1]};
			bus_timing <= m[0];
			tick(6);
			do_cmd(1'b1, 5'(3 + 7 * m), 8'hA5 ^ 8'(m), q);
			do_cmd(1'b0, 5'(3 + 7 * m), 8'h00, q);
			check("mode read", q, 8'hA5 ^ 8'(m));
			check("mode ctrl", ctrl[(3 + 7 * m) * 8 +: 8], 8'hA5 ^ 8'(m));
		end
		$display("test_modes done");
	endtask : test_modes

	task automatic test_edges();
		logic [7:0] q;
		do_cmd(1'b1, 5'h1C, 8'hFF, q);
		do_cmd(1'b0, 5'h1C, 8'h00, q);
		check("last ctrl", q, 8'hFF);
		check("last ctrl out", ctrl[231:224], 8'hFF);
		@(posedge clk);
		line_cond <= 7'h55;
		do_cmd(1'b1, `LIP_REG_LIVE, 8'h00, q);
		do_cmd(1'b0, `LIP_REG_LIVE, 8'h00, q);
		check("live", q, 8'h55);
		$display("test_edges done");
	endtask : test_edges

	task automatic test_irq();
		logic [7:0] q;
		do_cmd(1'b0, `LIP_REG_STATUS, 8'h00, q);
		do_cmd(1'b1, `LIP_REG_MASK, 8'h81, q);
		check("irq idle", {7'h00, irq}, 8'h00);
		@(posedge clk);
		line_cond <= 7'h54;
		tick(8);
		check("irq set", {7'h00, irq}, 8'h01);
		do_cmd(1'b0, `LIP_REG_STATUS, 8'h00, q);
		check("status", q, 8'h01);
		tick(6);
		check("irq clear", {7'h00, irq}, 8'h00);
		mclk_run = 1'b0;
		tick(70);
		check("irq mclk", {7'h00, irq}, 8'h01);
		mclk_run = 1'b1;
		tick(20);
		do_cmd(1'b0, `LIP_REG_STATUS, 8'h00, q);
		check("status mclk", q, 8'h80);
		tick(6);
		check("irq mclk clear", {7'h00, irq}, 8'h00);
		$display("test_irq done");
	endtask : test_irq

	task automatic test_hard_reset();
		logic [7:0] q;
		do_cmd(1'b1, 5'h00, 8'h3C, q);
		@(posedge clk);
		hard_reset <= 1'b1;
		tick(10);
		@(posedge clk);
		hard_reset <= 1'b0;
		tick(10);
		check("ctrl cleared", {7'h00, |ctrl}, 8'h00);
		do_cmd(1'b0, `LIP_REG_MASK, 8'h00, q);
		check("mask cleared", q, 8'h00);
		@(posedge clk);
		bus_sel <= 2'h2;
		tick(6);
		check("off refused", {7'h00, cmd_ready}, 8'h00);
		@(posedge clk);
		bus_sel <= 2'h0;
		tick(6);
		check("on ready", {7'h00, cmd_ready}, 8'h01);
		$display("test_hard_reset done");
	endtask : test_hard_reset

	// The second device sees a write strobe first without chip select, then with it.
	task automatic pulse2(input logic cs_n);
		@(posedge clk);
		bus2.chip_select_n <= cs_n;
		tick(4);
		@(posedge clk);
		bus2.write_strobe_n <= 1'b0;
		tick(8);
		@(posedge clk);
		bus2.write_strobe_n <= 1'b1;
		tick(8);
		@(posedge clk);
		bus2.chip_select_n <= 1'b1;
	endtask : pulse2

	task automatic test_cs_ignored();
		pulse2(1'b1);
		check("deselected write", ctrl2[31:24], 8'h00);
		pulse2(1'b0);
		check("selected write", ctrl2[31:24], 8'h5A);
		$display("test_cs_ignored done");
	endtask : test_cs_ignored

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	initial begin
		bus2.chip_select_n = 1'b1;
		bus2.read_strobe_n = 1'b1;
		bus2.write_strobe_n = 1'b1;
		bus2.addr_latch_strobe = 1'b0;
		bus2.separate_addr_inputs = 5'h03;
		bus2.bus_select_straps = `LIP_SEL_NONMUX;
		bus2.bus_timing_strap = 1'b0;
		bus2.hard_reset_n = 1'b1;
		bus2.host_data = 8'h5A;
		bus2.host_data_oe = 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		tick(4);
		test_modes();
		test_edges();
		test_irq();
		test_hard_reset();
		test_cs_ignored();
		results();
	end

	initial begin
		#(40 * 8000);
		n_mismatch++;
		$display("watchdog expired");
		results();
	end
endmodule : tb_line_interface_parallel_host_port

// ==== rtl/lip_bus_if.sv ====
// Pin bundle between the host end and the device end of the parallel port.
// Assumes both ends run on the same clock; the shared wires are resolved here from the enables.
interface lip_bus_if;
	logic       chip_select_n;
	logic       read_strobe_n;
	logic       write_strobe_n;
	logic       addr_latch_strobe;
	logic [4:0] separate_addr_inputs;
	logic [1:0] bus_select_straps;
	logic       bus_timing_strap;
	logic       hard_reset_n;
	logic [7:0] host_data;
	logic       host_data_oe;
	logic [7:0] dev_data;
	logic       dev_data_oe;
	logic [7:0] shared_addr_data_lines;
	logic       dev_irq;
	logic       dev_irq_oe;
	logic       irq_n;

	// Undriven data lines read as zero; the interrupt line has a pull-up.
	assign shared_addr_data_lines = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);
	assign irq_n = dev_irq_oe ? dev_irq : 1'b1;

	modport device (
		input  chip_select_n, read_strobe_n, write_strobe_n, addr_latch_strobe,
		input  separate_addr_inputs, bus_select_straps, bus_timing_strap, hard_reset_n,
		input  shared_addr_data_lines,
		output dev_data, dev_data_oe, dev_irq, dev_irq_oe
	);

	modport host (
		output chip_select_n, read_strobe_n, write_strobe_n, addr_latch_strobe,
		output separate_addr_inputs, bus_select_straps, bus_timing_strap, hard_reset_n,
		output host_data, host_data_oe,
		input  shared_addr_data_lines, irq_n
	);
endinterface : lip_bus_if

// ==== rtl/lip_device.sv ====
// Device end of the line interface parallel host port: pin decode, register file, status and interrupt.
// Assumes every pin arrives asynchronously and is synchronised here; user-side inputs share CLOCK_IN.
`include "lip_map.svh"

module lip_device
	import lip_pkg::*;
#(
	parameter int NUM_CTRL = 29 // Plain control registers from offset zero.
) (
	lip_bus_if.device                    bus,             // Parallel port pins.
	input  wire logic                    CLOCK_IN,        // System clock, 25 MHz.
	input  wire logic                    SRST_IN,         // Synchronous reset, active high.
	input  wire logic                    MASTER_CLOCK_IN, // Master clock pin, sampled.
	input  wire logic [6:0]              LINE_COND_IN,    // Line condition levels.
	output logic [NUM_CTRL*8-1:0]        LINE_CTRL_OUT    // Control register contents.
);

	localparam int SYNC_W = 22;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h7, 1'h0, 5'h00, 8'h00, 2'h0, 1'h0, 1'h1, 1'h0};
	localparam logic [`LIP_MCLK_CNT_W-1:0] MCLK_LOSS = `LIP_MCLK_CNT_W'(`LIP_MCLK_LOSS_CYC);

	function automatic logic is_ctrl(input logic [`LIP_ADDR_W-1:0] a);
		return int'(a) < NUM_CTRL;
	endfunction : is_ctrl

	// Pin synchronisers; only the second stage is read.
	logic [SYNC_W-1:0]  sync1;
	logic [SYNC_W-1:0]  sync2;
	logic               s_cs_n;
	logic               s_rd_n;
	logic               s_wr_n;
	logic               s_latch;
	logic [4:0]         s_addr;
	logic [7:0]         s_data;
	logic [1:0]         s_sel;
	logic               s_timing;
	logic               s_hard_reset_n;
	logic               s_mclk;

	// Registered state.
	logic [4:0]         addr_latch;
	logic               rd_act_q;
	logic               wr_act_q;
	logic               latch_q;
	logic               mclk_q;
	logic [`LIP_MCLK_CNT_W-1:0] mclk_cnt;
	logic [7:0]         cond_q;
	logic [7:0]         status;
	logic [7:0]         mask;
	logic [7:0]         ctrl [NUM_CTRL];
	logic [7:0]         dout;
	logic               doe;
	logic               irq_oe;

	logic [4:0]         next_addr_latch;
	logic               next_mclk_q;
	logic [`LIP_MCLK_CNT_W-1:0] next_mclk_cnt;
	logic [7:0]         next_cond_q;
	logic [7:0]         next_status;
	logic [7:0]         next_mask;
	logic [7:0]         next_ctrl [NUM_CTRL];
	logic [7:0]         next_dout;
	logic               next_doe;
	logic               next_irq_oe;

	// Decode results.
	lip_mode_type       mode;
	logic               muxed;
	logic               strobe_dir;
	logic               selected;
	logic               rd_act;
	logic               wr_act;
	logic               rd_end;
	logic               wr_end;
	logic [4:0]         addr;
	logic [7:0]         cond_now;
	logic [7:0]         clr;

	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end else begin
			sync1 <= {bus.chip_select_n, bus.read_strobe_n, bus.write_strobe_n, bus.addr_latch_strobe,
				bus.separate_addr_inputs, bus.shared_addr_data_lines, bus.bus_select_straps,
				bus.bus_timing_strap, bus.hard_reset_n, MASTER_CLOCK_IN};
			sync2 <= sync1;
		end
	end

	assign {s_cs_n, s_rd_n, s_wr_n, s_latch, s_addr, s_data, s_sel, s_timing, s_hard_reset_n, s_mclk} = sync2;

	always_comb begin
		mode      = lip_decode_mode(s_sel, s_timing);
		muxed     = (mode == LIP_MUX_SEP) || (mode == LIP_MUX_STROBE);
		strobe_dir = (mode == LIP_MUX_STROBE) || (mode == LIP_NONMUX_STROBE);
		selected  = (mode != LIP_OFF) && !s_cs_n;
		// In data-strobe timing the read pin qualifies and the write pin gives direction.
		rd_act = selected && !s_rd_n && (!strobe_dir || s_wr_n);
		wr_act = selected && (strobe_dir ? (!s_rd_n && !s_wr_n) : !s_wr_n);
		rd_end = rd_act_q && !rd_act;
		wr_end = wr_act_q && selected && (strobe_dir ? s_rd_n : s_wr_n);

		next_addr_latch = addr_latch;
		if (muxed && s_latch && !latch_q) begin
			next_addr_latch = s_data[4:0];
		end
		// The separate inputs are ignored in muxed mode, so a board that floats them still works.
		addr = muxed ? addr_latch : s_addr;

		// Either master clock rate toggles well inside the loss window.
		next_mclk_q   = s_mclk;
		next_mclk_cnt = mclk_cnt;
		if (s_mclk != mclk_q) begin
			next_mclk_cnt = '0;
		end else if (mclk_cnt != MCLK_LOSS) begin
			next_mclk_cnt = mclk_cnt + `LIP_MCLK_CNT_W'(1);
		end
		cond_now = {mclk_cnt == MCLK_LOSS, LINE_COND_IN};
		next_cond_q = cond_now;

		// Reading status clears only the bits the host saw; a new change in that cycle still sets.
		clr = (rd_end && (addr == `LIP_REG_STATUS)) ? dout : 8'h00;
		next_status = (status & ~clr) | (cond_now ^ cond_q);

		next_ctrl = ctrl;
		next_mask = mask;
		if (!s_hard_reset_n) begin
			for (int i = 0; i < NUM_CTRL; i++) begin
				next_ctrl[i] = `LIP_RESET_VAL;
			end
			next_mask = `LIP_RESET_VAL;
		end else if (wr_end) begin
			if (is_ctrl(addr)) begin
				next_ctrl[addr] = s_data;
			end else if (addr == `LIP_REG_MASK) begin
				next_mask = s_data;
			end
		end

		case (addr)
			`LIP_REG_LIVE: next_dout = cond_now;
			`LIP_REG_STATUS: next_dout = status;
			`LIP_REG_MASK: next_dout = mask;
			default: next_dout = is_ctrl(addr) ? ctrl[addr] : 8'h00;
		endcase
		next_doe    = rd_act;
		next_irq_oe = |(status & mask);
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			addr_latch <= 5'h00;
			rd_act_q   <= 1'b0;
			wr_act_q   <= 1'b0;
			latch_q    <= 1'b0;
			mclk_q     <= 1'b0;
			mclk_cnt   <= '0;
			cond_q     <= 8'h00;
			status     <= 8'h00;
			mask       <= `LIP_RESET_VAL;
			for (int i = 0; i < NUM_CTRL; i++) begin
				ctrl[i] <= `LIP_RESET_VAL;
			end
			dout       <= 8'h00;
			doe        <= 1'b0;
			irq_oe     <= 1'b0;
		end else begin
			addr_latch <= next_addr_latch;
			rd_act_q   <= rd_act;
			wr_act_q   <= wr_act;
			latch_q    <= s_latch;
			mclk_q     <= next_mclk_q;
			mclk_cnt   <= next_mclk_cnt;
			cond_q     <= next_cond_q;
			status     <= next_status;
			mask       <= next_mask;
			ctrl       <= next_ctrl;
			dout       <= next_dout;
			doe        <= next_doe;
			irq_oe     <= next_irq_oe;
		end
	end

	assign bus.dev_data    = dout;
	assign bus.dev_data_oe = doe;
	// Open drain: the level is always low and only the enable moves.
	assign bus.dev_irq     = 1'b0;
	assign bus.dev_irq_oe  = irq_oe;

	generate
		for (genvar g = 0; g < NUM_CTRL; g++) begin : g_ctrl_out
			assign LINE_CTRL_OUT[g*8 +: 8] = ctrl[g];
		end
	endgenerate

endmodule : lip_device

// ==== rtl/lip_host.sv ====
// Host end of the parallel port: turns one command at a time into a phased pin sequence.
// Assumes the device synchronises every pin; each phase is long enough for both synchronisers.
`include "lip_map.svh"

module lip_host
	import lip_pkg::*;
(
	lip_bus_if.host        bus,            // Parallel port pins.
	input  wire logic      CLOCK_IN,       // System clock, 25 MHz.
	input  wire logic      SRST_IN,        // Synchronous reset, active high.
	input  wire logic      CMD_VALID_IN,   // Command request.
	input  wire logic      CMD_WRITE_IN,   // One for write, zero for read.
	input  wire logic [4:0] CMD_ADDR_IN,   // Register offset.
	input  wire logic [7:0] CMD_DATA_IN,   // Write data.
	input  wire logic [1:0] BUS_SELECT_IN, // Bus select strap value.
	input  wire logic      BUS_TIMING_IN,  // Bus timing strap value.
	input  wire logic      HARD_RESET_IN,  // Hard reset request, active high.
	output logic           CMD_READY_OUT,  // Idle and able to take a command.
	output logic           RESP_VALID_OUT, // Command finished, one cycle.
	output logic [7:0]     RESP_DATA_OUT,  // Read data.
	output logic           IRQ_OUT         // Device interrupt pending.
);

	localparam logic [`LIP_PHASE_CNT_W-1:0] PHASE_LAST = `LIP_PHASE_CNT_W'(`LIP_PHASE_CYC - 1);

	lip_host_state_type state;
	lip_host_state_type next_state;
	logic [`LIP_PHASE_CNT_W-1:0] cnt;
	logic [`LIP_PHASE_CNT_W-1:0] next_cnt;
	logic        wr;
	logic        next_wr;
	logic [4:0]  cmd_addr;
	logic [4:0]  next_cmd_addr;
	logic [7:0]  cmd_data;
	logic [7:0]  next_cmd_data;
	logic [8:0]  sync1;
	logic [8:0]  sync2;
	logic [1:0]  sel;
	logic        timing;
	lip_mode_type mode;
	logic        muxed;
	logic        strobe_dir;
	logic        addr_phase;
	logic        data_phase;
	logic        next_ready;
	logic        next_resp_valid;
	logic [7:0]  next_resp_data;
	logic        next_cs_n;
	logic        next_rd_n;
	logic        next_wr_n;
	logic        next_latch;
	logic [4:0]  next_sep_addr;
	logic [7:0]  next_hdata;
	logic        next_hdata_oe;

	always_comb begin
		mode      = lip_decode_mode(sel, timing);
		muxed     = (mode == LIP_MUX_SEP) || (mode == LIP_MUX_STROBE);
		strobe_dir = (mode == LIP_MUX_STROBE) || (mode == LIP_NONMUX_STROBE);
		next_state      = state;
		next_cnt        = cnt + `LIP_PHASE_CNT_W'(1);
		next_wr         = wr;
		next_cmd_addr   = cmd_addr;
		next_cmd_data   = cmd_data;
		next_resp_valid = 1'b0;
		next_resp_data  = RESP_DATA_OUT;
		case (state)
			LIP_IDLE: begin
				next_cnt = '0;
				if (CMD_VALID_IN && CMD_READY_OUT) begin
					next_state    = LIP_ADDR;
					next_wr       = CMD_WRITE_IN;
					next_cmd_addr = CMD_ADDR_IN;
					next_cmd_data = CMD_DATA_IN;
				end
			end
			LIP_ADDR: if (cnt == PHASE_LAST) next_state = LIP_LATCH;
			LIP_LATCH: if (cnt == PHASE_LAST) next_state = LIP_SETUP;
			LIP_SETUP: if (cnt == PHASE_LAST) next_state = LIP_STROBE;
			LIP_STROBE: begin
				if (cnt == PHASE_LAST) begin
					next_state = LIP_RELEASE;
					if (!wr) begin
						next_resp_data = sync2[7:0];
					end
				end
			end
			LIP_RELEASE: begin
				if (cnt == PHASE_LAST) begin
					next_state      = LIP_IDLE;
					next_resp_valid = 1'b1;
				end
			end
			default: next_state = LIP_IDLE;
		endcase
		if (next_state != state) begin
			next_cnt = '0;
		end
		next_ready = (next_state == LIP_IDLE) && (mode != LIP_OFF);
		addr_phase = (next_state == LIP_ADDR) || (next_state == LIP_LATCH);
		data_phase = (next_state == LIP_SETUP) || (next_state == LIP_STROBE) || (next_state == LIP_RELEASE);
		next_cs_n     = (next_state == LIP_IDLE);
		next_latch    = muxed && (next_state == LIP_LATCH);
		next_sep_addr = (!muxed && (next_state != LIP_IDLE)) ? next_cmd_addr : 5'h00;
		next_hdata_oe = (muxed && addr_phase) || (next_wr && data_phase);
		next_hdata    = addr_phase ? {3'h0, next_cmd_addr} : next_cmd_data;
		// Data-strobe timing holds direction low from setup through release of a write so the strobe edge sees it.
		next_rd_n = !((next_state == LIP_STROBE) && (strobe_dir || !next_wr));
		next_wr_n = strobe_dir ? !(next_wr && data_phase) : !(next_wr && (next_state == LIP_STROBE));
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			state                    <= LIP_IDLE;
			cnt                      <= '0;
			wr                       <= 1'b0;
			cmd_addr                 <= 5'h00;
			cmd_data                 <= 8'h00;
			sync1                    <= 9'h100;
			sync2                    <= 9'h100;
			sel                      <= 2'h0;
			timing                   <= 1'b0;
			CMD_READY_OUT            <= 1'b0;
			RESP_VALID_OUT           <= 1'b0;
			RESP_DATA_OUT            <= 8'h00;
			IRQ_OUT                  <= 1'b0;
			bus.chip_select_n        <= 1'b1;
			bus.read_strobe_n        <= 1'b1;
			bus.write_strobe_n       <= 1'b1;
			bus.addr_latch_strobe    <= 1'b0;
			bus.separate_addr_inputs <= 5'h00;
			bus.bus_select_straps    <= 2'h0;
			bus.bus_timing_strap     <= 1'b0;
			bus.hard_reset_n         <= 1'b0;
			bus.host_data            <= 8'h00;
			bus.host_data_oe         <= 1'b0;
		end else begin
			state                    <= next_state;
			cnt                      <= next_cnt;
			wr                       <= next_wr;
			cmd_addr                 <= next_cmd_addr;
			cmd_data                 <= next_cmd_data;
			sync1                    <= {bus.irq_n, bus.shared_addr_data_lines};
			sync2                    <= sync1;
			sel                      <= BUS_SELECT_IN;
			timing                   <= BUS_TIMING_IN;
			CMD_READY_OUT            <= next_ready;
			RESP_VALID_OUT           <= next_resp_valid;
			RESP_DATA_OUT            <= next_resp_data;
			IRQ_OUT                  <= !sync2[8];
			bus.chip_select_n        <= next_cs_n;
			bus.read_strobe_n        <= next_rd_n;
			bus.write_strobe_n       <= next_wr_n;
			bus.addr_latch_strobe    <= next_latch;
			bus.separate_addr_inputs <= next_sep_addr;
			bus.bus_select_straps    <= sel;
			bus.bus_timing_strap     <= timing;
			bus.hard_reset_n         <= !HARD_RESET_IN;
			bus.host_data            <= next_hdata;
			bus.host_data_oe         <= next_hdata_oe;
		end
	end

endmodule : lip_host

// ==== rtl/lip_map.svh ====
// Constants for the line interface parallel host port: offsets, strap codes and timing counts.
// Assumes it is included by the package and by both ends; it holds definitions only.
`ifndef LIP_MAP_SVH
`define LIP_MAP_SVH

`define LIP_ADDR_W         5
`define LIP_DATA_W         8
`define LIP_RESET_VAL      8'h00

// Register offsets that sit above the plain control registers.
`define LIP_REG_LIVE       5'h1D
`define LIP_REG_STATUS     5'h1E
`define LIP_REG_MASK       5'h1F

// Bus select strap codes; the third strap picks separate or data-strobe timing.
`define LIP_SEL_MUX        2'h0
`define LIP_SEL_NONMUX     2'h1

// Status bit that reports a stopped master clock.
`define LIP_STAT_MCLK_BIT  7

// System clock period and derived cycle counts.
`define LIP_CLK_NS         40
`define LIP_PHASE_NS       320
`define LIP_PHASE_CYC      ((`LIP_PHASE_NS + `LIP_CLK_NS - 1) / `LIP_CLK_NS)
`define LIP_PHASE_CNT_W    4
`define LIP_MCLK_LOSS_NS   2000
`define LIP_MCLK_LOSS_CYC  (`LIP_MCLK_LOSS_NS / `LIP_CLK_NS)
`define LIP_MCLK_CNT_W     8

`endif

// ==== rtl/lip_pkg.sv ====
// Types shared by both ends of the parallel host port.
// Assumes lip_map.svh is on the include path.
`include "lip_map.svh"

package lip_pkg;

	typedef enum logic [2:0] {
		LIP_MUX_SEP,
		LIP_MUX_STROBE,
		LIP_NONMUX_SEP,
		LIP_NONMUX_STROBE,
		LIP_OFF
	} lip_mode_type;

	typedef enum logic [2:0] {
		LIP_IDLE,
		LIP_ADDR,
		LIP_LATCH,
		LIP_SETUP,
		LIP_STROBE,
		LIP_RELEASE
	} lip_host_state_type;

	// Both ends read the straps the same way, so the decode lives here.
	function automatic lip_mode_type lip_decode_mode(input logic [1:0] sel, input logic timing);
		if (sel == `LIP_SEL_MUX) begin
			return timing ? LIP_MUX_STROBE : LIP_MUX_SEP;
		end else if (sel == `LIP_SEL_NONMUX) begin
			return timing ? LIP_NONMUX_STROBE : LIP_NONMUX_SEP;
		end
		return LIP_OFF;
	endfunction : lip_decode_mode

endpackage : lip_pkg
